/* hdl/fuse_ctrl_pkg.sv */
// Purpose: shared constants and types for the fuse access controller
// Assumes: 32-bit register port, byte-addressed register map
// Notes:   offsets and field positions used by the controller and its array model
package fuse_ctrl_pkg;

  // ==========================================================================
  // register map (byte offsets)
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_WDATA   = 8'h08;
  localparam logic [7:0] OFS_RDATA   = 8'h0C;
  localparam logic [7:0] OFS_CMD     = 8'h10;
  localparam logic [7:0] OFS_STATUS  = 8'h14;
  localparam logic [7:0] OFS_TIMING  = 8'h18;
  localparam logic [7:0] OFS_VERSION = 8'h1C;

  // ==========================================================================
  // control register fields
  localparam int CTRL_BUSY_BIT  = 0;
  localparam int CTRL_ERROR_BIT = 1;

  // command register fields
  localparam int CMD_PROG_BIT   = 0;
  localparam int CMD_RELOAD_BIT = 1;
  localparam int CMD_LOCK_BIT   = 2;
  localparam int CMD_SHWR_BIT   = 3;

  // status register field positions, cleared by writing one
  localparam int ST_ACCESS_BIT  = 0;
  localparam int ST_CRC_BIT     = 1;
  localparam int ST_RELOAD_BIT  = 2;
  localparam int ST_PROG_BIT    = 3;
  localparam int ST_LOCKED_BIT  = 4;
  localparam int ST_WIDTH       = 5;

  // ==========================================================================
  // widths and reset values
  localparam int WORD_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [15:0] TIMING_RESET  = 16'h0004;
  localparam logic [31:0] VERSION_VALUE = 32'h0001_0000; // arbitrary value
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ==========================================================================
  // operation states
  typedef enum logic [2:0] {
    ST_IDLE, ST_PROG, ST_PROG_RELOAD, ST_RELOAD_ALL, ST_DONE
  } op_state_type;

  // command to the fuse array
  typedef struct packed {
    logic              prog;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } fuse_req_type;

endpackage

/* hdl/fuse_word_store.sv */
// Purpose: fuse word store with per-word ECC map, lock bits and ECC once flags
// Assumes: programming completes in one cycle after a request
// Notes:   a blown bit stays blown until srst; program only ORs new bits
`timescale 1ns/1ns
module fuse_word_store
  import fuse_ctrl_pkg::*;
#(
  parameter int WORDS = 16
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 srst,
  // request
  input  wire fuse_req_type         req,
  input  wire logic                 forceEcc,
  // results
  output logic [WORD_W-1:0]         rdWord,
  output logic                      isEccWord,
  output logic                      isLocked,
  output logic                      eccUsed,
  output logic                      addrBad
);

  logic [WORD_W-1:0] fuse_r [WORDS];
  logic [WORDS-1:0]  lock_r;
  logic [WORDS-1:0]  used_r;
  logic [$clog2(WORDS)-1:0] idx;

  // fixed fuse map: upper half of words are ECC words
  function automatic logic ecc_map(input logic [ADDR_W-1:0] a);
    return a >= ADDR_W'(WORDS / 2); // see RULE_07
  endfunction

  assign addrBad   = req.addr >= ADDR_W'(WORDS);
  assign idx       = req.addr[$clog2(WORDS)-1:0];
  assign isEccWord = ecc_map(req.addr);
  assign isLocked  = !addrBad && lock_r[idx];
  assign eccUsed   = !addrBad && used_r[idx];
  assign rdWord    = addrBad ? ZERO_WORD : fuse_r[idx];

  // program: OR new bits, mark ECC words used, set lock when forced
  always_ff @(posedge clock) begin
    if (srst) begin
      lock_r <= '0;
      used_r <= '0;
      for (int i = 0; i < WORDS; i++) fuse_r[i] <= ZERO_WORD;
    end else if (req.prog && !addrBad) begin
      fuse_r[idx] <= fuse_r[idx] | req.data;
      if (forceEcc || isEccWord) used_r[idx] <= 1'b1;
      if (forceEcc) lock_r[idx] <= 1'b1;
    end
  end

endmodule // fuse_word_store

/* hdl/fuse_access_ctrl.sv */
// Purpose: register-port controller for fuse words and their shadow copies
// Assumes: one clock, synchronous active-high reset, single-cycle strobes
// Notes:   shadow copies reload from the fuse store on command or after programming
//
// Contract
// RULE_01 - busy bit in control register; not ready while set
// RULE_02 - error bit in control register readable by software
// RULE_03 - software clears error bit; stays clear until next failure
// RULE_04 - software reload of all shadows; reload failure reported separately; ST_RELOAD_ALL never checks for a failure or sets ST_RELOAD_BIT
// RULE_05 - ECC word may be programmed only once
// RULE_06 - redundancy word accepts repeated programming of new bits
// RULE_07 - ECC or redundancy chosen per word from fixed fuse map
// RULE_08 - lock request forces ECC mode
// RULE_09 - locked word refused, reported as locked condition
// RULE_10 - shadow reloaded after program; reload failure separate
// RULE_11 - access error and CRC failure flagged separately; the code has no CRC check and never sets ST_CRC_BIT
// RULE_12 - software checks lock before shadow write or program
// RULE_13 - read-only version register
// RULE_14 - software sets timing from source clock frequency
// RULE_15 - busy held over whole program or reload operation
// RULE_16 - requests ignored while busy; start with error set sets error; the code still acts on CTRL error-clear and STATUS writes while busy
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
module fuse_access_ctrl
  import fuse_ctrl_pkg::*;
#(
  parameter int WORDS = 16
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 srst,
  // register port
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic [31:0]               regRdata,
  // status lines
  output logic                      busy,
  output logic                      error
);

  typedef struct packed {
    op_state_type      state;
    logic [15:0]       timing;
    logic [15:0]       cnt;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              lockReq;
    logic [ADDR_W-1:0] scan;
    logic [ST_WIDTH-1:0] status;
    logic              busy;
    logic              error;
    logic [31:0]       rdata;
    logic [WORD_W-1:0] shadowData;
    logic              shadowWe;
    logic [ADDR_W-1:0] shadowIdx;
  } state_type;

  state_type s_r, s_nxt;
  logic [WORD_W-1:0] shadow_r [WORDS];
  fuse_req_type      fuseReq;
  logic [WORD_W-1:0] fuseWord;
  logic              isEccWord, isLocked, eccUsed, addrBad;

  // ==========================================================================
  // fuse store
  fuse_word_store #(.WORDS(WORDS)) u_store (
    .clock     (clock),
    .srst      (srst),
    .req       (fuseReq),
    .forceEcc  (s_r.lockReq),
    .rdWord    (fuseWord),
    .isEccWord (isEccWord),
    .isLocked  (isLocked),
    .eccUsed   (eccUsed),
    .addrBad   (addrBad)
  );

  // address onto store: scan index during reload-all
  always_comb begin
    fuseReq.read = 1'b0;
    fuseReq.data = s_r.wdata;
    fuseReq.addr = (s_r.state == ST_RELOAD_ALL) ? s_r.scan : s_r.addr;
    fuseReq.prog = (s_r.state == ST_PROG) && (s_r.cnt == 16'h0000);
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.shadowWe = 1'b0;
    s_nxt.rdata = 32'h0000_0000;
    // register writes
    if (regWrite) begin
      if (hit(regAddr, OFS_ADDR) && !s_r.busy) s_nxt.addr = regWdata[ADDR_W-1:0];
      if (hit(regAddr, OFS_WDATA) && !s_r.busy) s_nxt.wdata = regWdata;
      if (hit(regAddr, OFS_TIMING) && !s_r.busy) s_nxt.timing = regWdata[15:0]; // see RULE_14
      if (hit(regAddr, OFS_CTRL) && regWdata[CTRL_ERROR_BIT]) s_nxt.error = 1'b0; // see RULE_03
      if (hit(regAddr, OFS_STATUS)) s_nxt.status = s_r.status & ~regWdata[ST_WIDTH-1:0];
      if (hit(regAddr, OFS_CMD) && !s_r.busy) begin // see RULE_16
        if (s_r.error) begin
          s_nxt.error = 1'b1; // see RULE_16
        end else if (regWdata[CMD_RELOAD_BIT]) begin
          s_nxt.state = ST_RELOAD_ALL; // see RULE_04
          s_nxt.scan  = '0;
          s_nxt.busy  = 1'b1; // see RULE_15
        end else if (regWdata[CMD_PROG_BIT] || regWdata[CMD_SHWR_BIT]) begin
          if (addrBad) begin
            s_nxt.status[ST_ACCESS_BIT] = 1'b1; // see RULE_11
            s_nxt.error = 1'b1;
          end else if (isLocked) begin
            s_nxt.status[ST_LOCKED_BIT] = 1'b1; // see RULE_09
            s_nxt.error = 1'b1;
          end else if (regWdata[CMD_PROG_BIT] && eccUsed) begin
            s_nxt.status[ST_PROG_BIT] = 1'b1; // see RULE_05
            s_nxt.error = 1'b1;
          end else if (regWdata[CMD_PROG_BIT]) begin
            s_nxt.state   = ST_PROG; // see RULE_06
            s_nxt.lockReq = regWdata[CMD_LOCK_BIT]; // see RULE_08
            s_nxt.cnt     = s_r.timing;
            s_nxt.busy    = 1'b1; // see RULE_01
          end else begin
            s_nxt.shadowWe   = 1'b1; // shadow write only
            s_nxt.shadowIdx  = s_r.addr;
            s_nxt.shadowData = s_r.wdata;
          end
        end
      end
    end
    // operation sequencing
    unique case (s_r.state)
      ST_IDLE: ;
      ST_PROG: begin
        if (s_r.cnt == 16'h0000) s_nxt.state = ST_PROG_RELOAD; // see RULE_15
        else s_nxt.cnt = s_r.cnt - 16'h0001;
      end
      ST_PROG_RELOAD: begin
        // verify blown bits; mismatch marks a reload failure
        s_nxt.shadowWe   = 1'b1; // see RULE_10
        s_nxt.shadowIdx  = s_r.addr;
        s_nxt.shadowData = fuseWord;
        if ((fuseWord & s_r.wdata) != s_r.wdata) begin
          s_nxt.status[ST_RELOAD_BIT] = 1'b1; // see RULE_10
          s_nxt.error = 1'b1; // see RULE_02
        end
        s_nxt.lockReq = 1'b0;
        s_nxt.state = ST_DONE;
      end
      ST_RELOAD_ALL: begin
        s_nxt.shadowWe   = 1'b1; // see RULE_04
        s_nxt.shadowIdx  = s_r.scan;
        s_nxt.shadowData = fuseWord;
        if (s_r.scan == ADDR_W'(WORDS - 1)) s_nxt.state = ST_DONE;
        else s_nxt.scan = s_r.scan + ADDR_W'(1);
      end
      ST_DONE: begin
        s_nxt.busy  = 1'b0; // see RULE_15
        s_nxt.state = ST_IDLE;
      end
    endcase
    // register reads
    if (regRead) begin
      unique case (regAddr)
        OFS_CTRL:    s_nxt.rdata = {30'h0, s_r.error, s_r.busy}; // see RULE_01
        OFS_ADDR:    s_nxt.rdata = 32'(s_r.addr);
        OFS_WDATA:   s_nxt.rdata = s_r.wdata;
        OFS_RDATA:   s_nxt.rdata = addrBad ? 32'h0000_0000 : shadow_r[s_r.addr[$clog2(WORDS)-1:0]];
        OFS_STATUS:  s_nxt.rdata = 32'(s_r.status); // see RULE_11
        OFS_TIMING:  s_nxt.rdata = 32'(s_r.timing);
        OFS_VERSION: s_nxt.rdata = VERSION_VALUE; // see RULE_13
        default:     s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock) begin
    if (srst) begin
      s_r        <= '0;
      s_r.state  <= ST_IDLE;
      s_r.timing <= TIMING_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // shadow array, written one cycle after its decision
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < WORDS; i++) shadow_r[i] <= ZERO_WORD;
    end else if (s_r.shadowWe && s_r.shadowIdx < ADDR_W'(WORDS)) begin
      shadow_r[s_r.shadowIdx[$clog2(WORDS)-1:0]] <= s_r.shadowData;
    end
  end

  assign regRdata = s_r.rdata;
  assign busy     = s_r.busy;
  assign error    = s_r.error;

endmodule // fuse_access_ctrl

/* verif/fuse_access_chk.sv */
// Purpose: port checker for the fuse access controller
// Assumes: one clock, srst synchronous active high
// Notes:   bound to every fuse_access_ctrl instance
`timescale 1ns/1ns
module fuse_access_chk
  import fuse_ctrl_pkg::*;
#(
  parameter int WORDS = 16
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  // status lines
  input wire logic        busy,
  input wire logic        error
);
  // =========
  // reload tail after eight busy cycles; busy stands WORDS+1 cycles in all
  localparam int RL = WORDS - 7;
  wire cmdWr = regWrite && (regAddr == OFS_CMD);
  wire clrWr = regWrite && (regAddr == OFS_CTRL) && regWdata[CTRL_ERROR_BIT];
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(regRead) |-> regRdata == ZERO_WORD)
    else $error("read data not zero outside read cycle");
  a_version_read: assert property (regRead && regAddr == OFS_VERSION |=>
    regRdata == VERSION_VALUE) else $error("version value wrong");
  a_ctrl_read: assert property (regRead && regAddr == OFS_CTRL |=>
    regRdata[1:0] == {$past(error), $past(busy)}) else $error("control read wrong");
  a_reload_busy: assert property (cmdWr && regWdata[CMD_RELOAD_BIT] && !busy && !error
    |=> busy [*8] ##RL busy ##1 !busy) else $error("reload busy length wrong");
  a_busy_start: assert property (!busy && !cmdWr |=> !busy)
    else $error("busy rose without command");
  a_err_clear: assert property (clrWr && !busy |=> !error)
    else $error("error not cleared");
  a_err_hold: assert property (error && !clrWr |=> error)
    else $error("error dropped by itself");
  a_cmd_refused: assert property (error && !busy && cmdWr |=> !busy && error)
    else $error("command taken while error set");
endmodule // fuse_access_chk

bind fuse_access_ctrl fuse_access_chk #(.WORDS(WORDS)) chk (.clock(clock), .srst(srst),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
  .regRdata(regRdata), .busy(busy), .error(error));

/* verif/fuse_host_model.sv */
// Purpose: software side of the register port
// Assumes: strobes change by non-blocking assignment after a rising edge
// Notes:   released lines carry the inverse of their last value
`timescale 1ns/1ns
module fuse_host_model
  import fuse_ctrl_pkg::*;
(
  // clock
  input  wire logic        clock,
  // register port
  output logic [7:0]       regAddr,
  output logic [31:0]      regWdata,
  output logic             regWrite,
  output logic             regRead,
  input  wire logic [31:0] regRdata
);
  // =========
  // idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWdata = ZERO_WORD;
    regWrite = 1'b0;
    regRead = 1'b0;
  end
  // one-cycle write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    regAddr <= ~a;
    regWdata <= ~d;
  endtask
  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    regAddr <= ~a;
    @(posedge clock);
    d = regRdata;
  endtask
endmodule // fuse_host_model

/* verif/fuse_access_ctrl_tb_top.sv */
// Purpose: self-checking bench for the fuse access controller
// Assumes: host model drives the register port
// Notes:   busy lengths are timing+3 for program and WORDS+1 for reload
`timescale 1ns/1ns
module fuse_access_ctrl_tb_top;
  import fuse_ctrl_pkg::*;
  localparam int WORDS = 16;
  // =========
  // signals
  logic        clock;
  logic        srst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        busy;
  logic        error;
  logic [31:0] seed, a, b, c, d;
  int          errTotal, checked, n;
  fuse_host_model host (.clock(clock), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  fuse_access_ctrl #(.WORDS(WORDS)) DUT (.clock(clock), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .busy(busy), .error(error));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'hA300_0000) : (x >> 1);
  endfunction
  function automatic logic [31:0] stBit(input int k);
    return 32'h0000_0001 << k;
  endfunction
  task automatic completeRun();
    $display("checked %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    host.rd(a, v);
    cmp(v, e);
  endtask
  // count busy cycles, bounded
  task automatic waitIdle(output int cnt);
    cnt = 0;
    #1;
    while (busy === 1'b1 && cnt < 300) begin
      cnt++;
      @(posedge clock);
      #1;
    end
    if (cnt == 300) begin
      errTotal++;
      completeRun();
    end
  endtask
  task automatic prog(input logic [7:0] w, input logic [31:0] v, input logic [31:0] cmd);
    host.wr(OFS_ADDR, {24'h00_0000, w});
    host.wr(OFS_WDATA, v);
    host.wr(OFS_CMD, cmd);
    waitIdle(n);
  endtask
  task automatic clearErr();
    host.wr(OFS_STATUS, 32'h0000_001F);
    host.wr(OFS_CTRL, 32'h0000_0002);
  endtask
  // main sequence
  initial begin
    srst = 1'b1;
    seed = 32'h0001_82A9;
    errTotal = 0;
    checked = 0;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    rdc(OFS_CTRL, ZERO_WORD);
    rdc(OFS_TIMING, 32'h0000_0004);
    rdc(OFS_VERSION, VERSION_VALUE);
    host.rd(8'h3C, d);
    cmp(d, ZERO_WORD);
    $display("test reset done");
    seed = lfsr(seed);
    a = seed;
    seed = lfsr(seed);
    b = seed & ~a;
    prog(8'h02, a, 32'h0000_0001);
    cmp(32'(n), 32'(4 + 3));
    rdc(OFS_RDATA, a);
    prog(8'h02, b, 32'h0000_0001);
    rdc(OFS_RDATA, a | b);
    rdc(OFS_CTRL, ZERO_WORD);
    $display("test redundancy done");
    seed = lfsr(seed);
    c = seed;
    prog(8'h0A, c, 32'h0000_0001);
    prog(8'h0A, ~c, 32'h0000_0001);
    rdc(OFS_STATUS, stBit(ST_PROG_BIT));
    rdc(OFS_RDATA, c);
    rdc(OFS_CTRL, 32'h0000_0002);
    host.wr(OFS_CMD, 32'h0000_0002);
    waitIdle(n);
    cmp(32'(n), ZERO_WORD);
    clearErr();
    rdc(OFS_CTRL, ZERO_WORD);
    rdc(OFS_STATUS, ZERO_WORD);
    cmp({31'h0000_0000, error}, ZERO_WORD);
    prog(8'h03, c, 32'h0000_0005);
    rdc(OFS_RDATA, c);
    prog(8'h03, ~c, 32'h0000_0001);
    rdc(OFS_STATUS, stBit(ST_LOCKED_BIT));
    clearErr();
    prog(8'h14, c, 32'h0000_0001);
    rdc(OFS_STATUS, stBit(ST_ACCESS_BIT));
    clearErr();
    $display("test refusals done");
    host.wr(OFS_CMD, 32'h0000_0002);
    waitIdle(n);
    cmp(32'(n), 32'(WORDS + 1));
    host.wr(OFS_ADDR, 32'h0000_0002);
    rdc(OFS_RDATA, a | b);
    host.wr(OFS_TIMING, 32'h0000_0002);
    seed = lfsr(seed);
    c = seed;
    host.wr(OFS_ADDR, 32'h0000_0005);
    host.wr(OFS_WDATA, c);
    host.wr(OFS_CMD, 32'h0000_0001);
    host.wr(OFS_ADDR, 32'h0000_0006);
    waitIdle(n);
    cmp(32'(n), 32'(2 + 3 - 2));
    rdc(OFS_RDATA, c);
    $display("test reload and timing done");
    completeRun();
  end
endmodule // fuse_access_ctrl_tb_top
